// >>> pmas_monitor_setup.sv
// Measurement setup, calibration and shunt result logic of the power monitor
`timescale 1ns/1ps

module pmas_monitor_setup #(
	parameter int unsigned CT_CYC [8]   = pmas_pkg::CT_CYC_DEF,
	parameter int unsigned DLY_STEP_CYC = pmas_pkg::DLY_STEP_CYC
) (
	input  wire logic                          core_clk,
	input  wire logic                          resetn,
	input  wire logic [pmas_pkg::ADDR_W-1:0]   reg_addr,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	input  wire logic [pmas_pkg::DATA_W-1:0]   reg_wdata,
	output logic      [pmas_pkg::DATA_W-1:0]   reg_rdata,
	input  wire logic                          shunt_range_select,
	input  wire logic [pmas_pkg::DLY_W-1:0]    initial_conversion_delay,
	input  wire logic [pmas_pkg::DATA_W-1:0]   adc_sample,
	output logic      [2:0]                    adc_chan,
	output logic                               adc_range,
	output logic                               seq_done,
	output logic      [pmas_pkg::DATA_W-1:0]   current_result
);

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	// Next enabled channel above cur in bus, shunt, temp order; zero when none
	function automatic pmas_pkg::pmas_chan_t next_chan(input pmas_pkg::pmas_chan_t mask,
		input pmas_pkg::pmas_chan_t cur);
		pmas_pkg::pmas_chan_t res;
		logic                 past;
		res  = 3'h0;
		past = (cur == 3'h0);
		for (int i = 0; i < 3; i++)
		begin
			if (past && mask[i] && res == 3'h0)
				res[i] = 1'b1;
			if (cur[i])
				past = 1'b1;
		end
		return res;
	endfunction : next_chan
	// Conversion time in cycles for a time code
	function automatic logic [pmas_pkg::CNT_W-1:0] ct_cycles(input logic [2:0] code);
		return pmas_pkg::CNT_W'(CT_CYC[code]);
	endfunction : ct_cycles

	// ------------------------------------------------------------
	// Registers and engine state
	// ------------------------------------------------------------
	pmas_pkg::pmas_setup_t            setup_ff;
	logic [pmas_pkg::CAL_W-1:0]        cal_ff;
	logic [pmas_pkg::DATA_W-1:0]       shunt_ff;
	logic [pmas_pkg::DATA_W-1:0]       rdata_ff;
	logic [pmas_pkg::DATA_W-1:0]       current_ff;
	logic                              range_ff;
	pmas_pkg::pmas_state_t             state_ff;
	pmas_pkg::pmas_chan_t              chan_ff;
	logic [pmas_pkg::CNT_W-1:0]        cnt_ff;
	logic [pmas_pkg::REP_W-1:0]        rep_ff;
	logic signed [pmas_pkg::ACC_W-1:0] acc_ff;
	logic                              setup_wr;
	pmas_pkg::pmas_chan_t              mask;
	pmas_pkg::pmas_chan_t              first_chan;
	pmas_pkg::pmas_chan_t              after_chan;
	logic [2:0]                        cur_ct;
	logic [pmas_pkg::CNT_W-1:0]        cur_target;
	logic [pmas_pkg::CNT_W-1:0]        dly_target;
	logic [pmas_pkg::REP_W-1:0]        rep_last;
	logic                              conv_end;
	logic                              rep_end;
	logic signed [pmas_pkg::ACC_W-1:0] acc_sum;
	logic signed [pmas_pkg::ACC_W-1:0] acc_avg;
	logic signed [pmas_pkg::PROD_W-1:0] cur_prod;

	// ------------------------------------------------------------
	// Combinational decode
	// ------------------------------------------------------------
	// Low three mode bits enable channels; zero means shutdown
	assign setup_wr   = reg_wr && (reg_addr == pmas_pkg::ADDR_SETUP);
	assign mask       = setup_ff.mode[2:0];
	assign first_chan = next_chan(mask, 3'h0);
	assign after_chan = next_chan(mask, chan_ff);
	assign dly_target = pmas_pkg::CNT_W'(initial_conversion_delay * DLY_STEP_CYC);
	assign rep_last   = pmas_pkg::REP_W'((1 << pmas_pkg::AVG_SHIFT[setup_ff.sample_average_count])
		- 1);
	// Each channel uses its own conversion time field
	always_comb
	begin
		cur_ct = setup_ff.temp_conv_time;
		if (chan_ff[pmas_pkg::CH_BUS])
			cur_ct = setup_ff.bus_conv_time;
		else if (chan_ff[pmas_pkg::CH_SHUNT])
			cur_ct = setup_ff.shunt_conv_time;
	end
	assign cur_target = ct_cycles(cur_ct);
	assign conv_end   = (state_ff == pmas_pkg::ST_CONV) && (cnt_ff == cur_target - 1'b1);
	// One repetition covers every enabled channel, so the count is shared
	assign rep_end    = conv_end && (after_chan == 3'h0);
	assign seq_done   = rep_end && (rep_ff == rep_last);
	assign acc_sum    = acc_ff + (chan_ff[pmas_pkg::CH_SHUNT] ?
		pmas_pkg::ACC_W'($signed(adc_sample)) : '0);                 // Temperature adds nothing
	assign acc_avg    = acc_sum >>> pmas_pkg::AVG_SHIFT[setup_ff.sample_average_count];

	// ------------------------------------------------------------
	// Conversion setup register
	// ------------------------------------------------------------
	// All fields writable; reset leaves continuous all-channel operation
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			setup_ff <= pmas_pkg::SETUP_RST;
		else if (setup_wr)
			setup_ff <= reg_wdata;
	end

	// ------------------------------------------------------------
	// Shunt calibration constant
	// ------------------------------------------------------------
	// Top bit is not stored, so it can only read back as zero
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			cal_ff <= pmas_pkg::CAL_RST;
		else if (reg_wr && reg_addr == pmas_pkg::ADDR_CAL)
			cal_ff <= reg_wdata[pmas_pkg::CAL_W-1:0];
	end

	// ------------------------------------------------------------
	// Measurement sequencer
	// ------------------------------------------------------------
	// A mode write restarts everything, even mid-sequence
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_ff <= pmas_pkg::ST_DELAY;
			chan_ff  <= 3'h0;
			cnt_ff   <= '0;
			rep_ff   <= '0;
		end
		else if (setup_wr)
		begin
			cnt_ff  <= '0;
			chan_ff <= 3'h0;
			rep_ff  <= '0;
			if (reg_wdata[pmas_pkg::DATA_W-2 -: 3] == 3'h0)          // Low three mode bits
				state_ff <= pmas_pkg::ST_IDLE;
			else
				state_ff <= pmas_pkg::ST_DELAY;
		end
		else
		begin
			case (state_ff)
				pmas_pkg::ST_IDLE:
				begin
					cnt_ff  <= '0;
					chan_ff <= 3'h0;
				end
				pmas_pkg::ST_DELAY:
				begin
					if (mask == 3'h0)
						state_ff <= pmas_pkg::ST_IDLE;
					else if (cnt_ff >= dly_target)
					begin
						state_ff <= pmas_pkg::ST_CONV;
						chan_ff  <= first_chan;
						cnt_ff   <= '0;
						rep_ff   <= '0;
					end
					else
						cnt_ff <= cnt_ff + 1'b1;
				end
				pmas_pkg::ST_CONV:
				begin
					if (!conv_end)
						cnt_ff <= cnt_ff + 1'b1;
					else if (!rep_end)
					begin
						chan_ff <= after_chan;
						cnt_ff  <= '0;
					end
					else
					begin
						chan_ff <= first_chan;
						cnt_ff  <= '0;
						rep_ff  <= seq_done ? '0 : rep_ff + 1'b1;
						// Single shot parks until the mode is written again
						if (seq_done && !setup_ff.mode[pmas_pkg::MODE_CONT_BIT])
							state_ff <= pmas_pkg::ST_IDLE;
					end
				end
				default:
					state_ff <= pmas_pkg::ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Shunt accumulation and result
	// ------------------------------------------------------------
	// Sum shunt samples over the whole averaging run
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			acc_ff <= '0;
		else if (setup_wr || seq_done || state_ff != pmas_pkg::ST_CONV)
			acc_ff <= '0;
		else if (conv_end && chan_ff[pmas_pkg::CH_SHUNT])
			acc_ff <= acc_sum;
	end
	// Result moves only when the last conversion of the last repetition ends
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			shunt_ff <= pmas_pkg::SHUNT_RST;
		else if (seq_done && mask[pmas_pkg::CH_SHUNT])
			shunt_ff <= acc_avg[pmas_pkg::DATA_W-1:0];
	end

	// ------------------------------------------------------------
	// Range and current computation
	// ------------------------------------------------------------
	// Range goes to the front end; the shunt LSB weight follows it
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			range_ff <= 1'b0;
		else
			range_ff <= shunt_range_select;
	end
	// Product scaled by calibration; fine range carries four times the weight
	assign cur_prod = $signed(shunt_ff) * $signed({1'b0, cal_ff});

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			current_ff <= '0;
		else if (range_ff)
			current_ff <= pmas_pkg::DATA_W'(cur_prod >>> pmas_pkg::CUR_SHIFT_R1);
		else
			current_ff <= pmas_pkg::DATA_W'(cur_prod >>> pmas_pkg::CUR_SHIFT_R0);
	end

	// ------------------------------------------------------------
	// Register read port
	// ------------------------------------------------------------
	// Unlisted addresses read zero
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			rdata_ff <= '0;
		else if (reg_rd)
		begin
			case (reg_addr)
				pmas_pkg::ADDR_SETUP: rdata_ff <= setup_ff;
				pmas_pkg::ADDR_CAL:   rdata_ff <= {1'b0, cal_ff};
				pmas_pkg::ADDR_SHUNT: rdata_ff <= shunt_ff;
				default:              rdata_ff <= '0;
			endcase
		end
	end

	assign reg_rdata      = rdata_ff;
	assign current_result = current_ff;
	assign adc_range      = range_ff;
	assign adc_chan       = (state_ff == pmas_pkg::ST_CONV) ? chan_ff : 3'h0;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_shutdown_idle;
		@(posedge core_clk) disable iff (!resetn)
		(state_ff == pmas_pkg::ST_CONV) |-> (setup_ff.mode[2:0] != 3'h0);
	endproperty
	a_shutdown_idle: assert property (p_shutdown_idle) else $error("converting in shutdown");
	property p_chan_enabled;
		@(posedge core_clk) disable iff (!resetn)
		(state_ff == pmas_pkg::ST_CONV) |-> ($onehot(chan_ff) && (chan_ff & mask) != 3'h0);
	endproperty
	a_chan_enabled: assert property (p_chan_enabled) else $error("channel not enabled");
	property p_cont_repeat;
		@(posedge core_clk) disable iff (!resetn)
		(seq_done && setup_ff.mode[pmas_pkg::MODE_CONT_BIT] && !setup_wr)
			|=> (state_ff == pmas_pkg::ST_CONV && chan_ff == first_chan && cnt_ff == '0);
	endproperty
	a_cont_repeat: assert property (p_cont_repeat) else $error("continuous did not repeat");
	// A mode write right after the sequence may legally leave idle again
	property p_single_stop;
		@(posedge core_clk) disable iff (!resetn)
		(seq_done && !setup_ff.mode[pmas_pkg::MODE_CONT_BIT] && !setup_wr)
			|=> (state_ff == pmas_pkg::ST_IDLE)
			##1 (state_ff == pmas_pkg::ST_IDLE || $past(setup_wr));
	endproperty
	a_single_stop: assert property (p_single_stop) else $error("single shot kept running");
	property p_conv_len;
		@(posedge core_clk) disable iff (!resetn)
		(state_ff == pmas_pkg::ST_CONV) |-> (cnt_ff < cur_target);
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion overran its time");
	property p_result_hold;
		@(posedge core_clk) disable iff (!resetn)
		!seq_done |=> $stable(shunt_ff);
	endproperty
	a_result_hold: assert property (p_result_hold) else $error("shunt result moved early");
	property p_cal_read;
		@(posedge core_clk) disable iff (!resetn)
		(reg_rd && reg_addr == pmas_pkg::ADDR_CAL)
			|=> (reg_rdata == {1'b0, $past(cal_ff)});
	endproperty
	a_cal_read: assert property (p_cal_read) else $error("calibration read wrong");
	property p_delay_wait;
		@(posedge core_clk) disable iff (!resetn)
		(state_ff == pmas_pkg::ST_DELAY && cnt_ff < dly_target && !setup_wr)
			|=> (state_ff != pmas_pkg::ST_CONV);
	endproperty
	a_delay_wait: assert property (p_delay_wait) else $error("conversion before delay");

endmodule : pmas_monitor_setup

// >>> pmas_pkg.sv
// Constants, types and timing for the power monitor measurement setup block
package pmas_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_MHZ      = 20;
	localparam int unsigned DLY_STEP_US  = 2000;
	localparam int unsigned DLY_STEP_CYC = DLY_STEP_US * CLK_MHZ;
	localparam int unsigned CT_US [8]    = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
	localparam int unsigned CT_CYC_DEF [8] = '{
		50 * CLK_MHZ, 84 * CLK_MHZ, 150 * CLK_MHZ, 280 * CLK_MHZ,
		540 * CLK_MHZ, 1052 * CLK_MHZ, 2074 * CLK_MHZ, 4120 * CLK_MHZ};
	// Averaging counts 1,4,16,64,128,256,512,1024 as power-of-two shifts
	localparam int unsigned AVG_SHIFT [8] = '{0, 2, 4, 6, 7, 8, 9, 10};

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W   = 6;
	localparam int unsigned DATA_W   = 16;
	localparam int unsigned CAL_W    = 15;
	localparam logic [5:0]  ADDR_SETUP = 6'h01;
	localparam logic [5:0]  ADDR_CAL   = 6'h02;
	localparam logic [5:0]  ADDR_SHUNT = 6'h04;
	localparam logic [15:0] SETUP_RST  = 16'hFB68;
	localparam logic [14:0] CAL_RST    = 15'h1000;
	localparam logic [15:0] SHUNT_RST  = 16'h0000;

	// ------------------------------------------------------------
	// Engine sizing
	// ------------------------------------------------------------
	localparam int unsigned CNT_W  = 24;
	localparam int unsigned ACC_W  = 26;
	localparam int unsigned REP_W  = 11;
	localparam int unsigned DLY_W  = 8;
	localparam int unsigned PROD_W = 32;
	// Current scaling shift; fine range is four times finer per LSB
	localparam int unsigned CUR_SHIFT_R0 = 13;
	localparam int unsigned CUR_SHIFT_R1 = 11;

	// Channel one-hot positions and the continuous bit within the mode code
	localparam int unsigned CH_BUS   = 0;
	localparam int unsigned CH_SHUNT = 1;
	localparam int unsigned CH_TEMP  = 2;
	localparam int unsigned MODE_CONT_BIT = 3;

	// Conversion setup register layout
	typedef struct packed {
		logic [3:0] mode;
		logic [2:0] bus_conv_time;
		logic [2:0] shunt_conv_time;
		logic [2:0] temp_conv_time;
		logic [2:0] sample_average_count;
	} pmas_setup_t;

	typedef logic [2:0] pmas_chan_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_DELAY = 3'h2,
		ST_CONV  = 3'h4
	} pmas_state_t;

endpackage : pmas_pkg

// >>> pmas_adc_model.sv
// Converter front-end model feeding samples into the monitor setup block
`timescale 1ns/1ps

module pmas_adc_model (
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic [2:0]  adc_chan,
	input  wire logic [15:0] shunt_base,
	input  wire logic [15:0] shunt_step,
	input  wire logic        clr,
	output logic      [15:0] adc_sample
);
	logic [2:0]  chan_ff;
	logic [15:0] win_ff;
	logic [15:0] last_ff;

	// ------------------------------------------------------------
	// Window tracking
	// ------------------------------------------------------------
	// Steps each time adc_chan leaves the shunt channel, so averages with another channel enabled see new data
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			chan_ff <= 3'h0;
			win_ff  <= 16'h0000;
			last_ff <= 16'h0000;
		end
		else
		begin
			chan_ff <= adc_chan;
			last_ff <= adc_sample;
			if (clr)
				win_ff <= 16'h0000;
			else if (chan_ff[1] && !adc_chan[1])
				win_ff <= win_ff + 16'h0001;
		end
	end

	// Idle output flips every cycle so a stale value never matches
	always_comb
	begin
		if (adc_chan[1])
			adc_sample = shunt_base + win_ff * shunt_step;
		else if (adc_chan != 3'h0)
			adc_sample = ~shunt_base;
		else
			adc_sample = ~last_ff;
	end
endmodule : pmas_adc_model

// >>> pmas_monitor_setup_tb.sv
// Self-checking testbench for the monitor setup block
`timescale 1ns/1ps

module pmas_monitor_setup_tb;
	localparam int unsigned CT [8] = '{4, 5, 6, 7, 8, 9, 10, 11};
	localparam int unsigned SH [8] = '{0, 2, 4, 6, 7, 8, 9, 10};
	logic        core_clk, resetn, reg_wr, reg_rd, clr;
	logic [5:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, adc_sample, current_result, base, step, rd;
	logic        shunt_range_select, adc_range, seq_done, early;
	logic [7:0]  initial_conversion_delay;
	logic [2:0]  adc_chan;
	int          err_count, total_checks, n;
	int          cnt [3];
	logic [2:0]  order [$];

	pmas_monitor_setup #(.CT_CYC(CT), .DLY_STEP_CYC(3)) i_pmas_monitor_setup (
		.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.shunt_range_select(shunt_range_select),
		.initial_conversion_delay(initial_conversion_delay), .adc_sample(adc_sample),
		.adc_chan(adc_chan), .adc_range(adc_range), .seq_done(seq_done),
		.current_result(current_result));
	pmas_adc_model i_pmas_adc_model (.core_clk(core_clk), .resetn(resetn),
		.adc_chan(adc_chan), .shunt_base(base), .shunt_step(step), .clr(clr),
		.adc_sample(adc_sample));

	// ------------------------------------------------------------
	// Bus and check helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		total_checks++;
		if (got !== exp)
		begin
			$display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
			err_count++;
		end
	endtask : chk

	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Data lands one edge after the strobe, looked at mid-cycle
	task automatic rdr(input logic [5:0] a, output logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
	endtask : rdr

	// Shut down first so the result is quiet before the new sequence
	task automatic go(input pmas_pkg::pmas_setup_t s, input int max);
		wr(6'h01, 16'h0000);
		clr <= 1'b1;
		repeat (3) @(posedge core_clk);
		clr <= 1'b0;
		wr(6'h01, s);
		cnt = '{0, 0, 0};
		order.delete();
		early = 1'b0;
		rd = current_result;
		for (n = 0; n < max; n++)
		begin
			@(negedge core_clk);
			if (adc_chan != 3'h0)
			begin
				cnt[$clog2(adc_chan)]++;
				if (order.size() == 0 || order[$] != adc_chan)
					order.push_back(adc_chan);
			end
			if (seq_done === 1'b1)
				break;
			early = early | (current_result !== rd);
		end
		chk({15'h0, n < max}, 16'h0001, "no completion");
		chk({15'h0, early}, 16'h0000, "result moved early");
	endtask : go

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		rdr(6'h01, rd); chk(rd, 16'hFB68, "setup reset");
		rdr(6'h02, rd); chk(rd, 16'h1000, "cal reset");
		rdr(6'h04, rd); chk(rd, 16'h0000, "shunt reset");
		rdr(6'h03, rd); chk(rd, 16'h0000, "unmapped");
		wr(6'h02, 16'hFFFF);
		rdr(6'h02, rd); chk(rd, 16'h7FFF, "cal bit15");
		wr(6'h01, 16'h0000);
		rdr(6'h01, rd); chk(rd, 16'h0000, "setup written");
		rdr(6'h04, base);
		wr(6'h04, ~base);
		rdr(6'h04, rd); chk(rd, base, "shunt written");
		$display("test regs done");
	endtask : t_regs

	task automatic t_off;
		foreach (cnt[i])
		begin
			if (i == 2)
				break;
			wr(6'h01, 16'hF000);
			wr(6'h01, {i == 1, 15'h0000});
			early = 1'b0;
			repeat (50) @(negedge core_clk) early = early | (adc_chan != 3'h0);
			chk({15'h0, early}, 16'h0000, "shutdown converts");
		end
		$display("test shutdown done");
	endtask : t_off

	task automatic t_modes;
		logic [8:0] got, exp;
		for (int m = 1; m < 16; m++)
		begin
			if (m == 8)
				continue;
			go('{4'(m), 3'h0, 3'h0, 3'h0, 3'h0}, 100);
			got = 9'h000;
			exp = 9'h000;
			foreach (order[i]) got = {got[5:0], order[i]};
			for (int b = 0; b < 3; b++) if (m[b]) exp = {exp[5:0], 3'(1 << b)};
			chk({7'h0, got}, {7'h0, exp}, "channel order");
			repeat (2) @(negedge core_clk);
			chk({13'h0, adc_chan}, m < 8 ? 16'h0 : {13'h0, 3'(m & -m)}, "after seq");
			repeat (20) @(negedge core_clk);
			if (m < 8) chk({13'h0, adc_chan}, 16'h0000, "single restarted");
		end
		$display("test modes done");
	endtask : t_modes

	task automatic t_ct;
		pmas_pkg::pmas_setup_t s;
		for (int ch = 0; ch < 3; ch++)
			for (int c = 0; c < 8; c++)
			begin
				s = '{4'(1 << ch), 3'h0, 3'h0, 3'h0, 3'h0};
				if (ch == 0) s.bus_conv_time = 3'(c);
				if (ch == 1) s.shunt_conv_time = 3'(c);
				if (ch == 2) s.temp_conv_time = 3'(c);
				go(s, 200);
				chk(16'(cnt[ch]), 16'(CT[c]), "window length");
			end
		$display("test conversion times done");
	endtask : t_ct

	task automatic t_avg;
		int k;
		base = 16'h0100;
		step = 16'h0001;
		for (int a = 0; a < 8; a++)
		begin
			k = 1 << SH[a];
			go('{4'h3, 3'h0, 3'h0, 3'h0, 3'(a)}, 20000);
			chk(16'(cnt[0]), 16'(k * CT[0]), "bus reps");
			chk(16'(cnt[1]), 16'(k * CT[0]), "shunt reps");
			rdr(6'h04, rd);
			chk(rd, 16'((k * 256 + k * (k - 1) / 2) >> SH[a]), "average");
		end
		// Temperature window closes each repetition; it must not enter the average
		go('{4'h6, 3'h0, 3'h0, 3'h0, 3'h1}, 200);
		chk(16'(cnt[2]), 16'h0010, "temp reps");
		rdr(6'h04, rd);
		chk(rd, 16'h0101, "average with temp");
		$display("test averaging done");
	endtask : t_avg

	task automatic t_range;
		int p;
		base = 16'hFF00;
		step = 16'h0000;
		for (int r = 0; r < 2; r++)
			for (int c = 1; c < 3; c++)
			begin
				@(posedge core_clk);
				shunt_range_select <= r[0];
				wr(6'h02, 16'(c * 16'h0800));
				go('{4'h2, 3'h0, 3'h0, 3'h0, 3'h0}, 100);
				repeat (2) @(negedge core_clk);
				p = (-256 * c * 2048) >>> (r ? 11 : 13);
				chk(current_result, p[15:0], "current");
				chk({15'h0, adc_range}, 16'(r), "range");
				rdr(6'h04, rd); chk(rd, 16'hFF00, "signed shunt");
			end
		$display("test range done");
	endtask : t_range

	task automatic t_delay;
		for (int d = 0; d < 6; d += 5)
		begin
			@(posedge core_clk);
			initial_conversion_delay <= 8'(d);
			wr(6'h01, 16'h0000);
			wr(6'h01, 16'h2000);
			for (n = 0; n < 100 && adc_chan == 3'h0; n++) @(negedge core_clk);
			chk({15'h0, n > d * 3 && n <= d * 3 + 4}, 16'h1, "start delay");
		end
		$display("test delay done");
	endtask : t_delay

	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results

	// ------------------------------------------------------------
	// Clock, watchdog and main sequence
	// ------------------------------------------------------------
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// Whole run is about 17000 cycles; over three times that means a hang
	initial
	begin
		repeat (60000) @(posedge core_clk);
		$display("MISMATCH t=%0t watchdog expired", $time);
		err_count++;
		results();
	end

	initial
	begin
		{resetn, reg_wr, reg_rd, clr, shunt_range_select} = 5'h00;
		{reg_addr, reg_wdata, base, step, initial_conversion_delay} = '0;
		repeat (6) @(posedge core_clk);
		resetn <= 1'b1;
		t_regs();
		t_off();
		t_modes();
		t_ct();
		t_avg();
		t_range();
		t_delay();
		results();
	end
endmodule : pmas_monitor_setup_tb
